// ==== power_ctrl_pkg.sv ====
// Package: register map, field positions and counts for the auto power-down control
package power_ctrl_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CTRL0 = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CTRL2 = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
    // Control register 0 fields
    localparam int C0_UNIT_EN = 1;
    localparam int C0_SLOW_LOGIC = 3;
    localparam int C0_ARRAY_CLK_OFF = 4;
    localparam int C0_MCELL_CLK_OFF = 5;
    localparam logic [7:0] C0_WMASK = 8'h3A;
    // Control register 2 fields
    localparam int C2_WR_OFF = 2;
    localparam int C2_RD_OFF = 3;
    localparam int C2_PSEN_OFF = 4;
    localparam int C2_STROBE_OFF = 5;
    localparam logic [7:0] C2_WMASK = 8'h3C;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Status register fields
    localparam int ST_DOWN = 0;
    localparam int ST_COUNT_LSB = 4;
    // Inactivity counter
    localparam int IDLE_CNT_W = 4;
    localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = 4'hF;
    localparam logic [IDLE_CNT_W-1:0] IDLE_ZERO = 4'h0;
    localparam logic [31:0] PRDATA_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_COUNTING = 3'b010,
        ST_POWERED_DOWN = 3'b100
    } pd_state_t;
endpackage : power_ctrl_pkg

// ==== auto_power_down_control.sv ====
// Auto power-down control: idle counter, bus blocking, control register gating
//
// Overview of operation
// - Enabled unit counts when strobe idles
// - Fifteen idle clock periods raise power-down
// - Unit enable alone arms power-down entry
// - Strobe pulsing again leaves power-down
// - Select low or reset high wakes
// - Power-down blocks bus, deselects memories
// - Counter keeps module clock when blocked
// - Logic and ports never enter standby
// - Power-down holds I/O, tristates peripherals
// - Control0 bit 3 turns fast logic off
// - Select low enables memories; high disables
// - Control0 bits 4,5 cut module clock
// - Runtime writable blocking bits gate arrays
// - Control0 bit 1 enables idle unit
// - Control2 bits 2-5 cut strobes
// - Power-up clears registers; resets do not
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module auto_power_down_control
    import power_ctrl_pkg::*;
#(
    parameter int MCU_ADDR_W = 16,
    parameter int MCU_DATA_W = 8
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [power_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Microcontroller bus and control pins
    input wire logic addr_strobe,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic psen_n,
    input wire logic [MCU_ADDR_W-1:0] mcu_addr,
    input wire logic [MCU_DATA_W-1:0] mcu_data,
    input wire logic module_clock_input,
    input wire logic chip_select_n,
    input wire logic reset_in,
    // Toward memories
    output logic [MCU_ADDR_W-1:0] mem_addr,
    output logic [MCU_DATA_W-1:0] mem_data,
    output logic mem_enable,
    output logic io_enable,
    // Toward programmable logic arrays
    output logic and_array_wr,
    output logic and_array_rd,
    output logic and_array_psen,
    output logic and_array_strobe,
    output logic and_array_clk,
    output logic macrocell_clk,
    output logic fast_logic_en,
    output logic logic_standby,
    // Port behaviour and status
    output logic power_down_flag,
    output logic pin_hold,
    output logic periph_tristate,
    output logic [power_ctrl_pkg::IDLE_CNT_W-1:0] idle_count
);
    import power_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [7:0] power_control_reg0;
    logic [7:0] power_control_reg2;
    pd_state_t state;
    pd_state_t next_state;

    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire hit_ctrl0 = (paddr == OFS_CTRL0);
    wire hit_ctrl2 = (paddr == OFS_CTRL2);
    wire hit_status = (paddr == OFS_STATUS);
    wire mapped = hit_ctrl0 || hit_ctrl2 || hit_status;
    wire wr_ctrl0 = access_phase && pwrite && hit_ctrl0;
    wire wr_ctrl2 = access_phase && pwrite && hit_ctrl2;

    wire [31:0] status_word = {20'h0_0000, idle_count, 3'b000, state == ST_POWERED_DOWN, 3'b000, power_down_flag};
    wire [31:0] read_mux = hit_ctrl0 ? {24'h00_0000, power_control_reg0} :
                           hit_ctrl2 ? {24'h00_0000, power_control_reg2} :
                           hit_status ? status_word : PRDATA_ZERO;

    // Zero-wait access: answer in the access cycle
    assign pready = access_phase;
    assign pslverr = access_phase && !mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= PRDATA_ZERO;
        else if (setup_phase && !pwrite)
            prdata <= read_mux;
    end

    // Only power-up (presetn) clears; reset_in leaves the contents
    // power-up clear only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_control_reg0 <= CTRL_RESET;
            power_control_reg2 <= CTRL_RESET;
        end
        else
        begin
            if (wr_ctrl0)
                power_control_reg0 <= pwdata[7:0] & C0_WMASK;
            if (wr_ctrl2)
                power_control_reg2 <= pwdata[7:0] & C2_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin edge detection
    logic strobe_prev;
    logic module_clock_input_prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_prev <= 1'b0;
            module_clock_input_prev <= 1'b0;
        end
        else
        begin
            strobe_prev <= addr_strobe;
            module_clock_input_prev <= module_clock_input;
        end
    end

    wire strobe_edge = addr_strobe ^ strobe_prev;
    // Raw pin feeds the counter, ignoring the clock blocking bits
    // counter clock unaffected
    wire module_clock_input_rise = module_clock_input && !module_clock_input_prev;
    wire unit_enable = power_control_reg0[C0_UNIT_EN];
    wire wake = strobe_edge || !chip_select_n || reset_in;

    ////////////////////////////////////////////////////////////////////////
    // Idle state machine and counter
    wire count_done = module_clock_input_rise && (idle_count == IDLE_LIMIT - 4'h1);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_RUN:
                if (unit_enable && !strobe_edge)
                    next_state = ST_COUNTING;
            ST_COUNTING:
                if (!unit_enable || strobe_edge)
                    next_state = ST_RUN;
                else if (count_done)
                    next_state = ST_POWERED_DOWN;
            ST_POWERED_DOWN:
                if (!unit_enable || wake)
                    next_state = ST_RUN;
            default:
                next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // clear on edge, advance per period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_count <= IDLE_ZERO;
        else if (!unit_enable || strobe_edge || next_state == ST_RUN)
            idle_count <= IDLE_ZERO;
        else if (state == ST_COUNTING && module_clock_input_rise)
            idle_count <= idle_count + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            power_down_flag <= 1'b0;
        else
            power_down_flag <= (next_state == ST_POWERED_DOWN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory side: frozen bus while down
    // block bus from memories
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_addr <= '0;
            mem_data <= '0;
        end
        else if (next_state != ST_POWERED_DOWN)
        begin
            mem_addr <= mcu_addr;
            mem_data <= mcu_data;
        end
    end

    assign mem_enable = !chip_select_n && !power_down_flag;
    assign io_enable = !chip_select_n;

    ////////////////////////////////////////////////////////////////////////
    // Logic array inputs, gated by blocking bits; the strobe also by power-down
    // strobe blocking bits
    assign and_array_wr = wr_n && !power_control_reg2[C2_WR_OFF];
    assign and_array_rd = rd_n && !power_control_reg2[C2_RD_OFF];
    assign and_array_psen = psen_n && !power_control_reg2[C2_PSEN_OFF];
    assign and_array_strobe = addr_strobe && !power_control_reg2[C2_STROBE_OFF] && !power_down_flag;
    assign and_array_clk = module_clock_input && !power_control_reg0[C0_ARRAY_CLK_OFF];
    assign macrocell_clk = module_clock_input && !power_control_reg0[C0_MCELL_CLK_OFF];
    // slow logic bit; clock derating is the system's job
    assign fast_logic_en = !power_control_reg0[C0_SLOW_LOGIC];
    assign logic_standby = 1'b0;
    assign pin_hold = power_down_flag;
    assign periph_tristate = power_down_flag;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_idle_period;
        unit_enable && !wake && state == ST_COUNTING && idle_count == 4'hE && module_clock_input_rise;
    endsequence

    sequence s_held_down;
        power_down_flag ##1 power_down_flag;
    endsequence

    // Counter parks at its limit while down; a wake or a cleared unit enable clears it
    a_count_to_down: assert property (s_last_idle_period |=> power_down_flag && idle_count == IDLE_LIMIT)
        else $error("power-down not raised after fifteen idle periods");
    a_down_cause: assert property ($rose(power_down_flag) |-> $past(idle_count) == 4'hE && $past(module_clock_input_rise))
        else $error("power-down raised without full idle count");
    a_strobe_clears: assert property (strobe_edge |=> idle_count == 4'h0 && !power_down_flag)
        else $error("strobe edge did not clear counter");
    a_wake_on_strobe: assert property (power_down_flag && strobe_edge |=> !power_down_flag)
        else $error("strobe pulsing did not wake");
    a_wake_on_select: assert property (power_down_flag && (!chip_select_n || reset_in) |=> !power_down_flag)
        else $error("select or reset did not wake");
    a_bus_frozen: assert property (s_held_down |-> $stable(mem_addr) && $stable(mem_data))
        else $error("bus reached memories in power-down");
    a_mem_deselect: assert property (power_down_flag || chip_select_n |-> !mem_enable)
        else $error("memories enabled while down or deselected");
    a_unit_disabled: assert property (!unit_enable |=> !power_down_flag ##1 idle_count == 4'h0)
        else $error("disabled unit still active");
    a_fast_mode: assert property (wr_ctrl0 |=> fast_logic_en == !$past(pwdata[C0_SLOW_LOGIC]))
        else $error("fast logic select does not follow write");
    a_clk_blocked: assert property (wr_ctrl0 && pwdata[C0_ARRAY_CLK_OFF] |=> !and_array_clk)
        else $error("module clock reached array while blocked");
    a_ctrl2_write: assert property (wr_ctrl2 |=> power_control_reg2 == ($past(pwdata[7:0]) & C2_WMASK))
        else $error("control register 2 write lost");
    a_count_on_block: assert property ((power_control_reg0[C0_MCELL_CLK_OFF] and s_last_idle_period) |=> power_down_flag)
        else $error("counter stopped by clock blocking");

endmodule : auto_power_down_control

// ==== mcu_bus_model.sv ====
// Microcontroller bus partner: address strobe, bus noise and module clock
`timescale 1ns/1ps
module mcu_bus_model (
    // Clock and commands
    input wire logic pclk,
    input wire logic strobe_on,
    input wire logic clk_on,
    // Pins toward the block
    output logic addr_strobe,
    output logic [15:0] mcu_addr,
    output logic [7:0] mcu_data,
    output logic module_clock_input
);
    logic [1:0] div = 2'd0;
    initial
    begin
        addr_strobe = 1'b0;
        mcu_addr = 16'h0000;
        mcu_data = 8'hFF;
        module_clock_input = 1'b0;
    end
    always @(posedge pclk)
    begin
        div <= div + 2'd1;
        // Bus keeps changing even while asleep, like noise from other devices
        mcu_addr <= mcu_addr + 16'h0001;
        mcu_data <= ~mcu_data;
        if (strobe_on)
            addr_strobe <= ~addr_strobe;
        // module clock toggles every second bus clock, a quarter of its rate
        if (clk_on && div[0])
            module_clock_input <= ~module_clock_input;
    end
endmodule : mcu_bus_model

// ==== test_auto_power_down_control.sv ====
// Self-checking bench for the auto power-down control
`timescale 1ns/1ps
module test_auto_power_down_control;
    import power_ctrl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic pready, pslverr, addr_strobe, module_clock_input, mem_enable, io_enable;
    logic wr_n = 1'b1, rd_n = 1'b1, psen_n = 1'b1, chip_select_n = 1'b1, reset_in = 1'b0;
    logic strobe_on = 1'b1, clk_on = 1'b1;
    logic [15:0] mcu_addr, mem_addr, a0;
    logic [7:0] mcu_data, mem_data, d0;
    logic and_array_wr, and_array_rd, and_array_psen, and_array_strobe, and_array_clk, macrocell_clk;
    logic fast_logic_en, logic_standby, power_down_flag, pin_hold, periph_tristate;
    logic [IDLE_CNT_W-1:0] idle_count;
    int failures = 0;
    int n_compared = 0;
    always #50 pclk = ~pclk;
    auto_power_down_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .addr_strobe, .wr_n, .rd_n, .psen_n, .mcu_addr, .mcu_data, .module_clock_input,
        .chip_select_n, .reset_in, .mem_addr, .mem_data, .mem_enable, .io_enable, .and_array_wr,
        .and_array_rd, .and_array_psen, .and_array_strobe, .and_array_clk, .macrocell_clk, .fast_logic_en,
        .logic_standby, .power_down_flag, .pin_hold, .periph_tristate, .idle_count);
    mcu_bus_model mdl (.pclk, .strobe_on, .clk_on, .addr_strobe, .mcu_addr, .mcu_data, .module_clock_input);
    ////////////////////////////////////////////////////////////////
    task final_report;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check
    // Caller enters just after a rising edge; one idle cycle follows
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic e_exp);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            failures++;
            final_report();
        end
        rdata = prdata;
        check({31'd0, pslverr}, {31'd0, e_exp}, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Flag is looked at mid-cycle where it is settled; returns just after a rising edge
    task automatic wait_flag(input logic lvl, input int lim, output int n);
        for (n = 0; n < lim; n++)
        begin
            @(negedge pclk);
            if (power_down_flag === lvl)
                break;
        end
        @(posedge pclk);
        if (n == lim)
        begin
            failures++;
            final_report();
        end
    endtask : wait_flag
    ////////////////////////////////////////////////////////////////
    task automatic gate_chk(input logic on);
        repeat (6)
        begin
            @(negedge pclk);
            check({and_array_wr, and_array_rd, and_array_psen, and_array_strobe, and_array_clk, macrocell_clk},
                on ? {wr_n, rd_n, psen_n, addr_strobe, module_clock_input, module_clock_input} : 6'd0, "gate");
        end
        @(posedge pclk);
    endtask : gate_chk
    task automatic t_regs;
        strobe_on <= 1'b0;
        repeat (100) @(posedge pclk);
        check({31'd0, power_down_flag}, 32'd0, "disabled unit slept");
        strobe_on <= 1'b1;
        apb(1'b0, OFS_CTRL0, 32'd0, 1'b0);
        check(rdata, 32'd0, "ctrl0 reset");
        apb(1'b0, OFS_CTRL2, 32'd0, 1'b0);
        check(rdata, 32'd0, "ctrl2 reset");
        apb(1'b1, OFS_CTRL0, 32'h0000_00F8, 1'b0);
        apb(1'b1, OFS_CTRL2, 32'h0000_00FF, 1'b0);
        apb(1'b0, OFS_CTRL2, 32'd0, 1'b0);
        check(rdata, 32'h0000_003C, "ctrl2 bits");
        check({31'd0, fast_logic_en}, 32'd0, "slow logic");
        gate_chk(1'b0);
        apb(1'b1, OFS_CTRL0, 32'd0, 1'b0);
        apb(1'b1, OFS_CTRL2, 32'd0, 1'b0);
        gate_chk(1'b1);
        apb(1'b1, 12'h00C, 32'h0000_00FF, 1'b1);
        apb(1'b0, 12'h00C, 32'd0, 1'b1);
        check(rdata, 32'd0, "unmapped read");
        chip_select_n <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        check({30'd0, mem_enable, io_enable}, 32'd3, "selected");
        chip_select_n <= 1'b1;
        @(posedge pclk);
        @(posedge pclk);
        check({30'd0, mem_enable, io_enable}, 32'd0, "deselected");
    endtask : t_regs
    // Enter power-down with the clock cut from the arrays, then wake three ways
    task automatic t_sleep_wake;
        int n;
        apb(1'b1, OFS_CTRL0, 32'h0000_0032, 1'b0);
        for (int c = 0; c < 3; c++)
        begin
            strobe_on <= 1'b0;
            @(posedge pclk);
            wait_flag(1'b1, 200, n);
            check({31'd0, n >= 50 && n <= 70}, 32'd1, "idle count span");
            check({29'd0, pin_hold, periph_tristate, logic_standby}, 32'd6, "port state");
            check({28'd0, idle_count}, {28'd0, IDLE_LIMIT}, "count held in power-down");
            apb(1'b0, OFS_STATUS, 32'd0, 1'b0);
            check(rdata, {20'd0, IDLE_LIMIT, 8'h11}, "status in power-down");
            a0 = mem_addr;
            d0 = mem_data;
            repeat (5) @(posedge pclk);
            check({16'd0, mem_addr}, {16'd0, a0}, "bus not blocked");
            check({24'd0, mem_data}, {24'd0, d0}, "data not blocked");
            if (c == 0)
                strobe_on <= 1'b1;
            if (c == 1)
                chip_select_n <= 1'b0;
            if (c == 2)
                reset_in <= 1'b1;
            @(posedge pclk);
            wait_flag(1'b0, 4, n);
            strobe_on <= 1'b1;
            chip_select_n <= 1'b1;
            reset_in <= 1'b0;
            repeat (4) @(posedge pclk);
            // Awake again: the bus reaches the memories one cycle late
            @(negedge pclk);
            check({16'd0, mem_addr}, {16'd0, mcu_addr - 16'h0001}, "bus not passed when awake");
            @(posedge pclk);
        end
        apb(1'b0, OFS_CTRL0, 32'd0, 1'b0);
        check(rdata, 32'h0000_0032, "kept over reset input");
    endtask : t_sleep_wake
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_sleep_wake();
        final_report();
    end
endmodule : test_auto_power_down_control
